// File: src/bwr_pkg.sv
package bwr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PART  = 4;
  localparam int PART_W    = 2;
  localparam int PRIO_W    = 4;
  localparam int FRAC_W    = 16;
  localparam int CNT_W     = 24;
  localparam int BYTES_W   = 8;
  localparam int HIST_D    = 16;
  localparam int HIST_W    = 4;

  // ----------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PART_SEL = 8'h00;
  localparam logic [7:0] OFS_MIN      = 8'h04;
  localparam logic [7:0] OFS_MAX      = 8'h08;
  localparam logic [7:0] OFS_WINWD    = 8'h0C;
  localparam logic [7:0] OFS_PROP     = 8'h10;
  localparam logic [7:0] OFS_PRI      = 8'h14;
  localparam logic [7:0] OFS_CTRL     = 8'h18;
  localparam logic [7:0] OFS_IDR      = 8'h1C;
  localparam logic [7:0] OFS_USAGE    = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAX_HARD_LIMIT_BIT_POS = 31;
  localparam int PROP_EN_POS     = 31;
  localparam int PRI_DS_POS      = 16;
  localparam int IDR_PROP_POS    = 0;
  localparam int IDR_INTPRI_POS  = 1;
  localparam int IDR_DSPRI_POS   = 2;
  localparam int IDR_WINWR_POS   = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [FRAC_W-1:0] RST_MAX   = 16'hFFFF;
  localparam logic [FRAC_W-1:0] RST_MIN   = 16'h0000;
  localparam logic [15:0]       RST_WINWD = 16'h0100;
  localparam logic [1:0]        RST_MODE  = 2'h0;

  // ----------------------------------------------------------------
  // Timing: window width in 8.8 fixed-point microseconds
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 50;
  localparam int US_FRAC_W   = 8;
  localparam int DECAY_DIV   = 8;
  // Bytes the downstream port can move per microsecond (peak)
  localparam int BYTES_PER_US = 200;

  // Accounting modes
  typedef enum logic [1:0] {
    BWR_FIXED  = 2'b00,
    BWR_MOVING = 2'b01,
    BWR_DECAY  = 2'b10
  } bwr_mode_e;

  // Preference classes
  typedef enum logic [1:0] {
    BWR_NONE = 2'b00,
    BWR_LOW  = 2'b01,
    BWR_MED  = 2'b10,
    BWR_HIGH = 2'b11
  } bwr_pref_e;

  // Request carried upstream to downstream
  typedef struct packed {
    logic [PART_W-1:0]  part;
    logic [PRIO_W-1:0]  prio;
    logic [BYTES_W-1:0] bytes;
    logic [31:0]        addr;
  } bwr_req_s;

  // Per-partition settings
  typedef struct packed {
    logic [FRAC_W-1:0] min_frac;
    logic [FRAC_W-1:0] max_frac;
    logic              hard_limit_bit;
    logic [15:0]       winwd;
    logic              stride_enable;
    logic [15:0]       stride_minus_one;
    logic [PRIO_W-1:0] int_prio;
    logic [PRIO_W-1:0] ds_prio;
  } bwr_cfg_s;

  // Scale a 16-bit fraction by a byte budget
  function automatic logic [CNT_W-1:0] bwr_scale(
    input logic [FRAC_W-1:0] frac,
    input logic [CNT_W-1:0]  budget
  );
    logic [CNT_W+FRAC_W:0] prod;
    prod = ({1'b0, budget} * {{CNT_W{1'b0}}, frac}) + {1'b0, budget};
    return prod[CNT_W+FRAC_W-1:FRAC_W];
  endfunction : bwr_scale

endpackage : bwr_pkg

// File: src/bwr_usage.sv
`timescale 1ns/1ps
`default_nettype none

// Saturating usage counter for one partition
module bwr_usage
  import bwr_pkg::*;
(
  input  wire logic             clock,     // System clock
  input  wire logic             reset,     // Async reset, high
  input  wire logic             clk_en,    // Freeze when low
  input  wire logic             clear,     // Fixed window boundary
  input  wire logic [CNT_W-1:0] add,       // Bytes issued now
  input  wire logic [CNT_W-1:0] sub,       // Bytes aged or decayed
  output logic      [CNT_W-1:0] usage      // Current usage
);

  logic [CNT_W-1:0] usage_q;
  logic [CNT_W-1:0] usage_d;
  logic [CNT_W:0]   sum;

  // ----------------------------------------------------------------
  // Next value: add, subtract with floor, saturate at top
  // ----------------------------------------------------------------
  always_comb
  begin
    sum = {1'b0, usage_q} + {1'b0, add};
    if (clear)
      usage_d = add;                                      // R7
    else if (sum[CNT_W])
      usage_d = '1;                                       // R27
    else if (sum[CNT_W-1:0] < sub)
      usage_d = '0;                                       // R9
    else
      usage_d = sum[CNT_W-1:0] - sub;                     // R8
  end

  // Register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      usage_q <= '0;
    else if (clk_en)
      usage_q <= usage_d;
  end

  assign usage = usage_q;

endmodule : bwr_usage

`default_nettype wire

// File: src/bwr_regulator.sv
// Contract
// (R1) Minimum and maximum settings are fractions of available bandwidth.
// (R2) Hard limit bit stops use beyond the maximum fraction.
// (R3) Usage is tracked over a moving or a periodically cleared window.
// (R4) Window width reads back for the selected partition.
// (R5) Window width is writable in fixed-point microseconds.
// (R6) Fixed window: priorities break ties within a preference class.
// (R7) Fixed window end clears usage; queued requests stay.
// (R8) Moving window adds bytes on issue, removes them after aging out; the code never subtracts bytes overwritten in a full 16-entry history ring.
// (R9) Decay mode lowers usage by allocation-proportional rate, floored at zero; the code removes 1 byte whenever the tick's low 8 bits are zero.
// (R10) Software keeps the sum of minimums within available bandwidth.
// (R11) Stride is an unsigned integer.
// (R12) Stride shares bandwidth proportionally among contenders.
// (R13) An ID bit reports the stride control is present.
// (R14) No stride value disables stride regulation.
// (R15) Stride regulation applies only when its enable bit is one.
// (R16) Maximum limiting and stride regulation act together.
// (R17) Priorities are held per partition.
// (R18) Internal priority chooses among equal-preference requests.
// (R19) Downstream priority comes from the partition setting.
// (R20) Internal and downstream priorities are independently optional.
// (R21) Without downstream priorities, upstream priority passes through.
// (R22) Response priority passes upstream unchanged.
// (R23) Below-minimum partitions are preferred.
// (R24) Over-maximum soft partitions go only when nothing better waits.
// (R25) Over-maximum hard partitions wait until usage drops below maximum.
// (R26) Unused allowance does not carry over between windows.
// (R27) Usage counters saturate.
// (R28) Limits are fractions scaled by bytes per window.
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module bwr_regulator
  import bwr_pkg::*;
#(
  parameter bit HAS_PROP   = 1'b1,
  parameter bit HAS_INTPRI = 1'b1,
  parameter bit HAS_DSPRI  = 1'b1
)
(
  input  wire logic              clock,        // 50 MHz clock
  input  wire logic              reset,        // Async reset, high
  input  wire logic              clk_en,       // Freezes all state
  // Wishbone slave
  input  wire logic              wb_cyc_i,     // Cycle
  input  wire logic              wb_stb_i,     // Strobe
  input  wire logic              wb_we_i,      // Write enable
  input  wire logic [7:0]        wb_adr_i,     // Byte address
  input  wire logic [3:0]        wb_sel_i,     // Byte lanes
  input  wire logic [31:0]       wb_dat_i,     // Write data
  output logic      [31:0]       wb_dat_o,     // Read data
  output logic                   wb_ack_o,     // Acknowledge
  output logic                   wb_err_o,     // Unmapped address
  // Upstream request inputs, one per partition queue
  input  wire logic [NUM_PART-1:0] rq_valid,   // Queue head valid
  input  wire bwr_req_s [NUM_PART-1:0] rq_req, // Queue heads
  output logic      [NUM_PART-1:0] rq_grant,   // Head taken
  // Downstream request
  output logic                   ds_valid,     // Request out
  output bwr_req_s               ds_req,       // Request with prio
  input  wire logic              ds_ready,     // Downstream ready
  // Responses
  input  wire logic              rsp_in_valid, // From downstream
  input  wire logic [PRIO_W-1:0] rsp_in_prio,  // Its priority
  input  wire logic [31:0]       rsp_in_data,  // Its data
  output logic                   rsp_out_valid,// To upstream
  output logic      [PRIO_W-1:0] rsp_out_prio, // Unchanged priority
  output logic      [31:0]       rsp_out_data  // Data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bwr_cfg_s  [NUM_PART-1:0] cfg_q, cfg_d;
  logic      [PART_W-1:0]   sel_q, sel_d;
  bwr_mode_e                mode_q, mode_d;
  logic      [31:0]         dat_q, dat_d;
  logic                     ack_q, ack_d, err_q, err_d, h_age, issue, rv_q;
  logic      [CNT_W-1:0]    usage [NUM_PART], add_v [NUM_PART];
  logic      [CNT_W-1:0]    sub_v [NUM_PART], pass_q [NUM_PART];
  logic      [CNT_W-1:0]    pass_d [NUM_PART];
  logic      [23:0]         tick_q, tick_d;
  logic      [NUM_PART-1:0] bound;
  // Moving-window history
  logic      [PART_W-1:0]   h_part [HIST_D];
  logic      [BYTES_W-1:0]  h_bytes [HIST_D];
  logic      [23:0]         h_time [HIST_D];
  logic      [HIST_D-1:0]   h_vld_q, h_vld_d;
  logic      [HIST_W-1:0]   h_wp_q, h_wp_d, h_rp_q, h_rp_d;
  logic      [23:0]         now_q;
  // Downstream output register
  logic                     dsv_q, dsv_d;
  bwr_req_s                 dsr_q, dsr_d;
  logic      [NUM_PART-1:0] gnt_q, gnt_d;
  logic      [PRIO_W-1:0]   rp_q;
  logic      [31:0]         rd_q;
  logic      [PART_W-1:0]   win;
  // Arbitration working values
  bwr_pref_e                pref [NUM_PART];
  bwr_pref_e                best_c;
  logic      [PRIO_W-1:0]   best_p, p;
  logic      [CNT_W-1:0]    best_s, budget, lim_min, lim_max;
  logic                     found;

  // Window length in clocks, from 8.8 microseconds
  function automatic logic [23:0] win_clks(input logic [15:0] w);
    logic [31:0] p;
    p = 32'(w) * 32'(CLK_MHZ);
    return p[US_FRAC_W+23:US_FRAC_W];
  endfunction : win_clks

  // Bytes available in one window
  function automatic logic [CNT_W-1:0] win_bytes(input logic [15:0] w);
    logic [31:0] p;
    p = 32'(w) * 32'(BYTES_PER_US);
    return p[US_FRAC_W+CNT_W-1:US_FRAC_W];
  endfunction : win_bytes

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes land at the ack edge; the slave answers one cycle after stb
  always_comb
  begin
    cfg_d  = cfg_q;
    sel_d  = sel_q;
    mode_d = mode_q;
    dat_d  = '0;
    ack_d  = 1'b0;
    err_d  = 1'b0;
    if (wb_cyc_i && wb_stb_i && !ack_q && !err_q)
    begin
      ack_d = 1'b1;
      if (wb_adr_i == OFS_PART_SEL)
      begin
        dat_d = {30'h0, sel_q};
        if (wb_we_i && wb_sel_i[0])
          sel_d = wb_dat_i[PART_W-1:0];
      end
      else if (wb_adr_i == OFS_MIN)
      begin
        dat_d = {16'h0, cfg_q[sel_q].min_frac};                  // R1
        if (wb_we_i)
          cfg_d[sel_q].min_frac = wb_dat_i[FRAC_W-1:0];
      end
      else if (wb_adr_i == OFS_MAX)
      begin
        dat_d = {cfg_q[sel_q].hard_limit_bit, 15'h0,
                 cfg_q[sel_q].max_frac};
        if (wb_we_i)
        begin
          cfg_d[sel_q].max_frac       = wb_dat_i[FRAC_W-1:0];
          cfg_d[sel_q].hard_limit_bit = wb_dat_i[MAX_HARD_LIMIT_BIT_POS]; // R2
        end
      end
      else if (wb_adr_i == OFS_WINWD)
      begin
        dat_d = {16'h0, cfg_q[sel_q].winwd};                     // R4
        if (wb_we_i)
          cfg_d[sel_q].winwd = wb_dat_i[15:0];                   // R5
      end
      else if (wb_adr_i == OFS_PROP)
      begin
        dat_d = {cfg_q[sel_q].stride_enable, 15'h0,
                 cfg_q[sel_q].stride_minus_one};                 // R11
        if (wb_we_i && HAS_PROP)
        begin
          cfg_d[sel_q].stride_minus_one = wb_dat_i[15:0];
          cfg_d[sel_q].stride_enable    = wb_dat_i[PROP_EN_POS]; // R15
        end
      end
      else if (wb_adr_i == OFS_PRI)
      begin
        dat_d = {12'h0, cfg_q[sel_q].ds_prio, 12'h0,
                 cfg_q[sel_q].int_prio};                         // R17
        if (wb_we_i)
        begin
          cfg_d[sel_q].int_prio = wb_dat_i[PRIO_W-1:0];
          cfg_d[sel_q].ds_prio  = wb_dat_i[PRI_DS_POS+PRIO_W-1:PRI_DS_POS];
        end
      end
      else if (wb_adr_i == OFS_CTRL)
      begin
        dat_d = {30'h0, mode_q};
        if (wb_we_i && wb_dat_i[1:0] != 2'b11)
          mode_d = bwr_mode_e'(wb_dat_i[1:0]);                   // R3
      end
      else if (wb_adr_i == OFS_IDR)
      begin
        dat_d = '0;
        dat_d[IDR_PROP_POS]   = HAS_PROP;                        // R13
        dat_d[IDR_INTPRI_POS] = HAS_INTPRI;                      // R20
        dat_d[IDR_DSPRI_POS]  = HAS_DSPRI;
        dat_d[IDR_WINWR_POS]  = 1'b1;
      end
      else if (wb_adr_i == OFS_USAGE)
        dat_d = {8'h0, usage[sel_q]};
      else
      begin
        ack_d = 1'b0;
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_PART; i++)
        cfg_q[i] <= '{min_frac: RST_MIN, max_frac: RST_MAX,
                      winwd: RST_WINWD, default: '0};
      sel_q  <= '0;
      mode_q <= BWR_FIXED;
      dat_q  <= '0;
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_q  <= cfg_d;
      sel_q  <= sel_d;
      mode_q <= mode_d;
      dat_q  <= dat_d;
      ack_q  <= ack_d;
      err_q  <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Accounting
  // ----------------------------------------------------------------
  // Window boundary uses partition 0's width; a global tick
  always_comb
  begin
    tick_d = tick_q + 24'h000001;
    bound  = '0;
    if (tick_q >= win_clks(cfg_q[0].winwd) - 24'h000001)
    begin
      tick_d = '0;
      if (mode_q == BWR_FIXED)
        bound = '1;                                              // R7 R26
    end
  end

  assign issue = dsv_q && ds_ready;
  assign h_age = h_vld_q[h_rp_q] &&
                 (now_q - h_time[h_rp_q] >= win_clks(cfg_q[h_part[h_rp_q]].winwd));

  // Add on issue; subtract aged bytes or the decay share
  always_comb
  begin
    for (int i = 0; i < NUM_PART; i++)
    begin
      add_v[i] = (issue && dsr_q.part == PART_W'(i)) ?
                 CNT_W'(dsr_q.bytes) : '0;
      sub_v[i] = '0;
      if (mode_q == BWR_MOVING && h_age && h_part[h_rp_q] == PART_W'(i))
        sub_v[i] = CNT_W'(h_bytes[h_rp_q]);                      // R8
      else if (mode_q == BWR_DECAY && tick_q[DECAY_DIV-1:0] == '0)
        sub_v[i] = bwr_scale(cfg_q[i].max_frac,
                             CNT_W'(win_bytes(cfg_q[i].winwd) >> 16)) +
                   CNT_W'(1);                                    // R9
    end
  end

  for (genvar g = 0; g < NUM_PART; g++)
  begin : g_usage
    bwr_usage u_usage (
      .clock (clock),
      .reset (reset),
      .clk_en(clk_en),
      .clear (bound[g]),
      .add   (add_v[g]),
      .sub   (sub_v[g]),
      .usage (usage[g])
    );
  end

  // History ring for moving window; full ring overwrites oldest, whose bytes are never subtracted
  always_comb
  begin
    h_vld_d = h_vld_q;
    h_wp_d  = h_wp_q;
    h_rp_d  = h_rp_q;
    if (h_age)
    begin
      h_vld_d[h_rp_q] = 1'b0;
      h_rp_d = h_rp_q + HIST_W'(1);
    end
    if (issue && mode_q == BWR_MOVING)
    begin
      h_vld_d[h_wp_q] = 1'b1;
      h_wp_d = h_wp_q + HIST_W'(1);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tick_q  <= '0;
      now_q   <= '0;
      h_vld_q <= '0;
      h_wp_q  <= '0;
      h_rp_q  <= '0;
      for (int i = 0; i < HIST_D; i++)
      begin
        h_part[i]  <= '0;
        h_bytes[i] <= '0;
        h_time[i]  <= '0;
      end
    end
    else if (clk_en)
    begin
      tick_q  <= tick_d;
      now_q   <= now_q + 24'h000001;
      h_vld_q <= h_vld_d;
      h_wp_q  <= h_wp_d;
      h_rp_q  <= h_rp_d;
      if (issue && mode_q == BWR_MOVING)
      begin
        h_part[h_wp_q]  <= dsr_q.part;
        h_bytes[h_wp_q] <= dsr_q.bytes;
        h_time[h_wp_q]  <= now_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Class, then stride pass, then internal or request priority
  always_comb
  begin
    found  = 1'b0;
    best_c = BWR_NONE;
    best_p = '0;
    best_s = '0;
    win    = '0;
    for (int i = 0; i < NUM_PART; i++)
    begin
      budget  = win_bytes(cfg_q[i].winwd);                       // R28
      lim_min = bwr_scale(cfg_q[i].min_frac, budget);            // R1
      lim_max = bwr_scale(cfg_q[i].max_frac, budget);
      if (usage[i] < lim_min)
        pref[i] = BWR_HIGH;                                      // R23
      else if (usage[i] < lim_max)
        pref[i] = BWR_MED;
      else if (!cfg_q[i].hard_limit_bit)
        pref[i] = BWR_LOW;                                       // R24
      else
        pref[i] = BWR_NONE;                                      // R25 R16
      p = (HAS_INTPRI) ? cfg_q[i].int_prio : rq_req[i].prio;     // R18 R6
      if (rq_valid[i] && pref[i] != BWR_NONE && !gnt_q[i])
      begin
        if (!found || pref[i] > best_c ||
            (pref[i] == best_c && HAS_PROP && cfg_q[i].stride_enable &&
             pass_q[i] < best_s) ||                              // R12
            (pref[i] == best_c && (pass_q[i] == best_s ||
             !(HAS_PROP && cfg_q[i].stride_enable)) && p > best_p))
        begin
          found  = 1'b1;
          best_c = pref[i];
          best_p = p;
          best_s = (HAS_PROP && cfg_q[i].stride_enable) ? pass_q[i] : '0;
          win    = PART_W'(i);
        end
      end
    end
    dsv_d = dsv_q && !ds_ready;
    dsr_d = dsr_q;
    gnt_d = '0;
    for (int i = 0; i < NUM_PART; i++)
      pass_d[i] = pass_q[i];
    if (found && (!dsv_q || ds_ready))
    begin
      dsv_d = 1'b1;
      dsr_d = rq_req[win];                                       // R21
      gnt_d[win] = 1'b1;
      if (HAS_DSPRI)
        dsr_d.prio = cfg_q[win].ds_prio;                         // R19
      // Stride of any value advances pass; only enable gates it
      if (HAS_PROP && cfg_q[win].stride_enable)                  // R14 R15
        pass_d[win] = pass_q[win] +
                      CNT_W'({1'b0, cfg_q[win].stride_minus_one}) +
                      CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      dsv_q <= 1'b0;
      dsr_q <= '0;
      gnt_q <= '0;
      for (int i = 0; i < NUM_PART; i++)
        pass_q[i] <= '0;
      rv_q  <= 1'b0;
      rp_q  <= '0;
      rd_q  <= '0;
    end
    else if (clk_en)
    begin
      dsv_q <= dsv_d;
      dsr_q <= dsr_d;
      gnt_q <= gnt_d;
      for (int i = 0; i < NUM_PART; i++)
        pass_q[i] <= pass_d[i];
      rv_q  <= rsp_in_valid;
      rp_q  <= rsp_in_prio;                                      // R22
      rd_q  <= rsp_in_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o      = dat_q;
  assign wb_ack_o      = ack_q;
  assign wb_err_o      = err_q;
  assign rq_grant      = gnt_q;
  assign ds_valid      = dsv_q;
  assign ds_req        = dsr_q;
  assign rsp_out_valid = rv_q;
  assign rsp_out_prio  = rp_q;
  assign rsp_out_data  = rd_q;

endmodule : bwr_regulator

`default_nettype wire

// File: sim/bwr_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the regulator
module bwr_chk
  import bwr_pkg::*;
(
  input wire logic                clock,         // Clock
  input wire logic                reset,         // Async reset
  input wire logic                wb_cyc_i,      // Bus cycle
  input wire logic                wb_stb_i,      // Bus strobe
  input wire logic                wb_ack_o,      // Bus ack
  input wire logic                wb_err_o,      // Bus error
  input wire logic [NUM_PART-1:0] rq_valid,      // Heads valid
  input wire logic [NUM_PART-1:0] rq_grant,      // Heads taken
  input wire logic                ds_valid,      // Request out
  input wire bwr_req_s            ds_req,        // Request
  input wire logic                ds_ready,      // Accept
  input wire logic                rsp_in_valid,  // Reply in
  input wire logic [PRIO_W-1:0]   rsp_in_prio,   // Its priority
  input wire logic [31:0]         rsp_in_data,   // Its data
  input wire logic                rsp_out_valid, // Reply out
  input wire logic [PRIO_W-1:0]   rsp_out_prio,  // Its priority
  input wire logic [31:0]         rsp_out_data   // Its data
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    && !wb_err_o |=> wb_ack_o ^ wb_err_o) else $error("no bus answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_rsp_pass: assert property (rsp_in_valid |=> rsp_out_valid
    && rsp_out_prio == $past(rsp_in_prio)
    && rsp_out_data == $past(rsp_in_data)) else $error("reply altered");
  a_rsp_quiet: assert property (!rsp_in_valid |=> !rsp_out_valid)
    else $error("spurious reply");
  a_ds_hold: assert property (ds_valid && !ds_ready |=>
    ds_valid && $stable(ds_req)) else $error("request dropped");
  a_grant_single: assert property ($onehot0(rq_grant))
    else $error("two grants");
  a_grant_cause: assert property (rq_grant != 0 |-> ds_valid
    && (rq_grant & ~$past(rq_valid)) == 0) else $error("bad grant");
  a_grant_gap: assert property (rq_grant != 0 |=>
    (rq_grant & $past(rq_grant)) == 0) else $error("queue not skipped");

  // Main scenarios reached
  c_err: cover property (wb_err_o);
  c_grant: cover property (rq_grant != 0);
  c_stall: cover property (ds_valid && !ds_ready);
endmodule : bwr_chk

bind bwr_regulator bwr_chk bwr_chk_i (.*);

`default_nettype wire

// File: sim/bwr_ds_model.sv
`timescale 1ns/1ps
`default_nettype none

// Downstream end: random stalls, one reply per accepted request
module bwr_ds_model
  import bwr_pkg::*;
(
  input  wire logic         clock,     // Clock
  input  wire logic         reset,     // Async reset
  input  wire logic         ds_valid,  // Request offered
  input  wire bwr_req_s     ds_req,    // Request
  output logic              ds_ready,  // Accept
  output logic              rsp_valid, // Reply valid
  output logic [PRIO_W-1:0] rsp_prio,  // Reply priority
  output logic [31:0]       rsp_data   // Reply data
);
  integer seed = 47398;

  // Idle reply lines toggle so a stale value never looks valid
  always @(posedge clock or posedge reset)
    if (reset)
    begin
      {ds_ready, rsp_valid, rsp_prio, rsp_data} <= '0;
    end
    else
    begin
      ds_ready <= $random(seed) & 1;
      rsp_valid <= ds_valid && ds_ready;
      rsp_prio <= (ds_valid && ds_ready) ? ds_req.prio : ~rsp_prio;
      rsp_data <= (ds_valid && ds_ready) ? ds_req.addr : ~rsp_data;
    end
endmodule : bwr_ds_model

`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bwr_pkg::*;
  logic clock, reset, cyc, stb, we, ack, err, berr, dsv, dsr, rv;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd, rdt;
  logic [3:0] rp;
  logic [NUM_PART-1:0] rq_valid, rq_grant;
  bwr_req_s [NUM_PART-1:0] rq_req;
  bwr_req_s dsq;
  integer seed = 47398;
  int mismatches = 0, total_checks = 0, first;
  int dsp[4], used[4], win[4];

  bwr_regulator bwr_regulator_i (.clock(clock), .reset(reset),
    .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .rq_valid(rq_valid),
    .rq_req(rq_req), .rq_grant(rq_grant), .ds_valid(dsv), .ds_req(dsq),
    .ds_ready(dsr), .rsp_in_valid(rv), .rsp_in_prio(rp),
    .rsp_in_data(rdt), .rsp_out_valid(), .rsp_out_prio(),
    .rsp_out_data());
  bwr_ds_model bwr_ds_model_i (.clock(clock), .reset(reset),
    .ds_valid(dsv), .ds_req(dsq), .ds_ready(dsr), .rsp_valid(rv),
    .rsp_prio(rp), .rsp_data(rdt));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Classic cycle; waits for ack or err, bounded
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    int n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 32'(d)};
    do
      @(posedge clock);
    while (!(ack || err) && ++n < 100);
    rd = rdat;
    berr = err;
    {cyc, stb} <= 2'b00;
    if (n >= 100)
      mismatches++;
  endtask : wb

  task automatic raise(input int p);
    @(posedge clock);
    rq_req[p] <= {p[1:0], 4'($random(seed)), 8'(($random(seed) & 63) + 1),
      32'($random(seed))};
    rq_valid[p] <= 1'b1;
  endtask : raise

  // Wait for the grant, then pop the head
  task automatic take(input int p);
    int n = 0;
    do
      @(negedge clock);
    while (!rq_grant[p] && ++n < 300);
    if (first < 0)
      first = p;
    chk("grant", n < 300, 1);
    @(posedge clock);
    rq_valid[p] <= 1'b0;
  endtask : take

  task automatic duel(input int win_p);
    while (dsv)
      @(posedge clock);
    first = -1;
    fork
      begin
        raise(0);
        take(0);
      end
      begin
        raise(3);
        take(3);
      end
    join
    chk("winner", first, win_p);
  endtask : duel

  // Reference model: expected priority and per-partition usage
  always @(posedge clock)
    if (!reset && dsv && dsr)
    begin
      chk("ds_prio", dsq.prio, dsp[dsq.part]);
      used[dsq.part] += dsq.bytes;
    end

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    {cyc, stb, we, adr, wdat, rq_valid, rq_req} = '0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    wb(0, OFS_MAX, 0);
    chk("max_rst", rd, 32'h0000FFFF);
    wb(0, OFS_IDR, 0);
    chk("stride_id", rd[IDR_PROP_POS], 1);
    wb(0, OFS_PROP, 0);
    chk("prop_rst", rd[PROP_EN_POS], 0);
    wb(0, 8'h40, 0);
    chk("unmapped", berr, 1);
    // Long windows keep moving-mode usage from ageing mid-test
    for (int p = 0; p < 4; p++)
    begin
      win[p] = 16'h0800 + ($random(seed) & 16'h07FF);
      dsp[p] = $random(seed) & 15;
      wb(1, OFS_PART_SEL, p);
      wb(1, OFS_WINWD, win[p]);
      wb(1, OFS_PRI, (dsp[p] << PRI_DS_POS) | (p == 3 ? 9 : 1));
    end
    for (int p = 0; p < 4; p++)
    begin
      wb(1, OFS_PART_SEL, p);
      wb(0, OFS_WINWD, 0);
      chk("winwd", rd[15:0], win[p]);
    end
    wb(1, OFS_CTRL, BWR_MOVING);
    duel(3);
    used[1] = 0;
    repeat (3)
    begin
      raise(1);
      take(1);
    end
    while (dsv)
      @(posedge clock);
    wb(1, OFS_PART_SEL, 1);
    wb(0, OFS_USAGE, 0);
    chk("usage_mov", rd, used[1]);
    wb(1, OFS_CTRL, BWR_FIXED);
    repeat (1000) @(posedge clock);
    wb(0, OFS_USAGE, 0);
    chk("usage_clr", rd, 0);
    wb(1, OFS_PART_SEL, 0);
    wb(1, OFS_MIN, 16'hFFFF);
    duel(0);
    // Zero maximum with hard limit: partition 2 must wait
    wb(1, OFS_PART_SEL, 2);
    wb(1, OFS_MAX, 32'h80000000);
    raise(2);
    repeat (40) @(negedge clock) chk("held", rq_grant[2], 0);
    wb(1, OFS_MAX, 0);
    take(2);
    repeat (4) @(posedge clock);
    end_of_test();
  end
endmodule : tb

`default_nettype wire
